/* core/dsa_splitter.v */
/*
 * Transfer splitter of the per-core transfer controller. A command moves
 * data between a local-storage address and a translated main-storage
 * address, or names a range for the transfer level-1 cache. The splitter
 * cuts it into indivisible pieces and queues them, in order, toward the
 * coherent main-storage interconnect through a four-word buffer.
 * Assumes one clock, a synchronous reset, and a far side that performs
 * each piece as one indivisible access in the order received.
 */
//
// Behaviour
// - Naturally aligned byte to quadword pieces stay whole.
// - Aligned whole cache lines go as one piece.
// - Other accesses split into disjoint indivisible pieces.
// - Oversized or misaligned transfers become several pieces.
// - Local side indivisible only for quadword pieces.
// - Local address always selects own local storage.
// - Range overlap undetected, no exception raised.
// - Overlap with lower source may corrupt source.
// - Range prefetch, zero, write back, flush commands.
// - Modified means changed locally, not yet written.
// - Instruction copies need not track later stores.
// - Present split instruction and data cache model.
// - Pieces to one location never reordered.
// - Four attributes; write-through with inhibited refused.
// - Attributes per page, only when translated here.
// - Range commands on WT/CI storage raise fault.
`timescale 1ns/1ns
`include "dsa_regs.vh"
module dsa_splitter #(
    parameter EA_W  = 64,
    parameter LS_AW = 18,
    parameter LEN_W = 15,
    parameter DEPTH = 4,
    parameter DAW   = 2
) (
    input  wire                                clk,
    input  wire                                rst,
    input  wire                                cmd_valid,
    output wire                                cmd_ready,
    input  wire [`DSA_OP_W-1:0]                cmd_op,
    input  wire [EA_W-1:0]                     cmd_ea,
    input  wire [LS_AW-1:0]                    cmd_ls,
    input  wire [LEN_W-1:0]                    cmd_len,
    input  wire [`DSA_ATTR_W-1:0]              cmd_attr,
    input  wire                                cmd_xlated,
    output reg                                 cmd_done,
    output reg                                 attr_error,
    output reg                                 storage_fault,
    output wire                                piece_valid,
    input  wire                                piece_ready,
    output wire [`DSA_OP_W-1:0]                piece_op,
    output wire [`DSA_SIZE_W-1:0]              piece_size,
    output wire [`DSA_ATTR_W-1:0]              piece_attr,
    output wire [LS_AW-1:0]                    piece_ls,
    output wire [EA_W-1:0]                     piece_ea,
    output wire                                busy
);
    localparam PW = `DSA_OP_W + `DSA_SIZE_W + `DSA_ATTR_W + LS_AW + EA_W;

    localparam [1:0] ST_IDLE  = 2'b01;
    localparam [1:0] ST_SPLIT = 2'b10;

    reg  [1:0]             state;
    reg  [1:0]             next_state;
    reg  [`DSA_OP_W-1:0]   cur_op;
    reg  [EA_W-1:0]        cur_ea;
    reg  [LS_AW-1:0]       cur_ls;
    reg  [LEN_W:0]         cur_len;
    reg  [`DSA_ATTR_W-1:0] cur_attr;

    wire                   fifo_in_ready;
    wire [PW-1:0]          fifo_out;
    wire                   cur_range;
    wire [`DSA_SIZE_W-1:0] size_now;
    wire [LEN_W:0]         step_now;
    wire                   push_piece;
    wire                   last_piece;
    wire [`DSA_ATTR_W-1:0] eff_attr;
    wire                   attr_bad;
    wire                   range_bad;
    wire                   take_cmd;

    // Range commands work on the transfer level-1 cache.
    function is_range;
        input [`DSA_OP_W-1:0] op;
        begin
            is_range = (op == `DSA_OP_RTOUCH) || (op == `DSA_OP_RTOUCHST) ||
                       (op == `DSA_OP_RZERO) || (op == `DSA_OP_RSTORE) ||
                       (op == `DSA_OP_RFLUSH);
        end
    endfunction

    // Largest piece that is naturally aligned on both sides and fits the
    // remaining length. A quadword is the widest piece below a line, since
    // only quadwords are indivisible in local storage. A line is used only
    // when both addresses sit on a line boundary.
    function [`DSA_SIZE_W-1:0] piece_log2;
        input [6:0]     ea_low;
        input [6:0]     ls_low;
        input [LEN_W:0] len;
        reg   [6:0]     both;
        begin
            both = ea_low | ls_low;
            if (both == 7'h00 && len >= {{(LEN_W-7){1'b0}}, `DSA_LINE_BYTES}) begin
                piece_log2 = `DSA_LINE_LOG2;
            end else if (both[3:0] == 4'h0 && len >= 16) begin
                piece_log2 = `DSA_QW_LOG2;
            end else if (both[2:0] == 3'h0 && len >= 8) begin
                piece_log2 = 3'h3;
            end else if (both[1:0] == 2'h0 && len >= 4) begin
                piece_log2 = 3'h2;
            end else if (both[0] == 1'b0 && len >= 2) begin
                piece_log2 = 3'h1;
            end else begin
                piece_log2 = 3'h0;
            end
        end
    endfunction

    assign cur_range = is_range(cur_op);

    // Range commands walk whole lines from a line-aligned start.
    assign size_now  = cur_range ? `DSA_LINE_LOG2 :
                       piece_log2(cur_ea[6:0], cur_ls[6:0], cur_len);
    assign step_now  = {{LEN_W{1'b0}}, 1'b1} << size_now;
    assign last_piece = (cur_len <= step_now);

    // Attributes only mean something when this controller translated the
    // address; otherwise coherent, cacheable storage is assumed. Pieces
    // never exceed a line, so they never cross a page and one attribute
    // set per command is enough.
    assign eff_attr  = cmd_xlated ? cmd_attr : `DSA_ATTR_DFLT;
    assign attr_bad  = eff_attr[`DSA_ATTR_WT] & eff_attr[`DSA_ATTR_CI];
    assign range_bad = is_range(cmd_op) &
                       (eff_attr[`DSA_ATTR_WT] | eff_attr[`DSA_ATTR_CI]);

    assign cmd_ready  = (state == ST_IDLE);
    assign take_cmd   = cmd_valid & cmd_ready;
    assign push_piece = (state == ST_SPLIT) & fifo_in_ready;
    assign busy       = (state != ST_IDLE) | piece_valid;

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take_cmd && !attr_bad && !range_bad && cmd_len != {LEN_W{1'b0}}) begin
                    next_state = ST_SPLIT;
                end
            end
            ST_SPLIT: begin
                if (push_piece && last_piece) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state         <= ST_IDLE;
            cur_op        <= `DSA_OP_GET;
            cur_ea        <= {EA_W{1'b0}};
            cur_ls        <= {LS_AW{1'b0}};
            cur_len       <= {(LEN_W+1){1'b0}};
            cur_attr      <= `DSA_ATTR_DFLT;
            cmd_done      <= 1'b0;
            attr_error    <= 1'b0;
            storage_fault <= 1'b0;
        end else begin
            state         <= next_state;
            cmd_done      <= 1'b0;
            attr_error    <= 1'b0;
            storage_fault <= 1'b0;
            if (take_cmd) begin
                cur_op   <= cmd_op;
                cur_attr <= eff_attr;
                // The local address is an offset into this controller's own
                // store; its width alone keeps it there.
                cur_ls   <= cmd_ls;
                if (is_range(cmd_op)) begin
                    cur_ea  <= {cmd_ea[EA_W-1:7], 7'h00};
                    cur_len <= {1'b0, cmd_len} + {{(LEN_W-6){1'b0}}, cmd_ea[6:0]};
                end else begin
                    cur_ea  <= cmd_ea;
                    cur_len <= {1'b0, cmd_len};
                end
                if (attr_bad) begin
                    attr_error <= 1'b1;
                end else if (range_bad) begin
                    storage_fault <= 1'b1;
                end else if (cmd_len == {LEN_W{1'b0}}) begin
                    cmd_done <= 1'b1;
                end
            end else if (push_piece) begin
                // No check of the main-storage range against our own local
                // range is made; overlapping copies may clobber the source,
                // and keeping them apart is software's job.
                cur_ea  <= cur_ea + {{(EA_W-LEN_W-1){1'b0}}, step_now};
                cur_ls  <= cur_ls + {{(LS_AW-LEN_W-1){1'b0}}, step_now};
                cur_len <= last_piece ? {(LEN_W+1){1'b0}} : cur_len - step_now;
                if (last_piece) begin
                    cmd_done <= 1'b1;
                end
            end
        end
    end

    // One in-order queue toward the interconnect: no piece overtakes an
    // earlier one, so stores and loads to one location keep their order.
    // Write-back and flush ranges carry every line of the range, modified or not, as the far cache
    // holds as modified; instruction copies are left to software, which
    // keeps the split instruction and data model.
    dsa_fifo #(
        .W     (PW),
        .DEPTH (DEPTH),
        .AW    (DAW)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (state == ST_SPLIT),
        .in_ready  (fifo_in_ready),
        .in_data   ({cur_op, size_now, cur_attr, cur_ls, cur_ea}),
        .out_valid (piece_valid),
        .out_ready (piece_ready),
        .out_data  (fifo_out)
    );

    assign piece_ea   = fifo_out[EA_W-1:0];
    assign piece_ls   = fifo_out[EA_W+LS_AW-1:EA_W];
    assign piece_attr = fifo_out[EA_W+LS_AW+`DSA_ATTR_W-1:EA_W+LS_AW];
    assign piece_size = fifo_out[PW-`DSA_OP_W-1:PW-`DSA_OP_W-`DSA_SIZE_W];
    assign piece_op   = fifo_out[PW-1:PW-`DSA_OP_W];
endmodule

/* core/dsa_regs.vh */
/*
 * Constants shared by the transfer splitter and its testbench: command
 * codes, attribute bit positions, piece size limits and piece word layout.
 * Assumes it is included by bare name from files under core/ and bench/.
 */
`ifndef DSA_REGS_VH
`define DSA_REGS_VH

// Command codes on cmd_op.
`define DSA_OP_GET      3'h0
`define DSA_OP_PUT      3'h1
`define DSA_OP_RTOUCH   3'h2
`define DSA_OP_RTOUCHST 3'h3
`define DSA_OP_RZERO    3'h4
`define DSA_OP_RSTORE   3'h5
`define DSA_OP_RFLUSH   3'h6

// Bit positions of the storage control attribute field.
`define DSA_ATTR_WT     0
`define DSA_ATTR_CI     1
`define DSA_ATTR_MC     2
`define DSA_ATTR_GD     3
`define DSA_ATTR_W      4
// Attributes assumed when the address was not translated here.
`define DSA_ATTR_DFLT   4'h4

// Size of a piece as log2 of its byte count.
`define DSA_QW_LOG2     3'h4
`define DSA_LINE_LOG2   3'h7
`define DSA_LINE_BYTES  8'h80

// Layout of a piece word, low bits first: ea, ls, attr, size, op.
`define DSA_OP_W        3
`define DSA_SIZE_W      3

`endif

/* core/dsa_fifo.v */
/*
 * Small flip-flop FIFO with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-high reset; DEPTH is a
 * power of two and AW is its log2.
 */
`timescale 1ns/1ns
module dsa_fifo #(
    parameter W     = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire         push;
    wire         pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end

    // Storage needs no reset; out_valid gates every stale word.
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

/* bench/dsa_splitter_asserts.sv */
/*
 * Checker on the splitter's ports: refusals, piece shape and piece hold.
 * Assumes one clock and a synchronous active-high reset; bound below.
 */
`timescale 1ns/1ns
module dsa_checker #(
    parameter EA_W  = 64,
    parameter LS_AW = 18,
    parameter LEN_W = 15
) (
    input wire             clk,
    input wire             rst,
    input wire             cmd_valid,
    input wire             cmd_ready,
    input wire [2:0]       cmd_op,
    input wire [LEN_W-1:0] cmd_len,
    input wire [3:0]       cmd_attr,
    input wire             cmd_xlated,
    input wire             cmd_done,
    input wire             attr_error,
    input wire             storage_fault,
    input wire             piece_valid,
    input wire             piece_ready,
    input wire [2:0]       piece_op,
    input wire [2:0]       piece_size,
    input wire [3:0]       piece_attr,
    input wire [LS_AW-1:0] piece_ls,
    input wire [EA_W-1:0]  piece_ea
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready;
    wire wtci = cmd_xlated && cmd_attr[0] && cmd_attr[1];
    wire one  = cmd_xlated && (cmd_attr[0] ^ cmd_attr[1]);
    a_attr_refuse: assert property (take && wtci |=> attr_error && !cmd_done)
        else $error("refused attribute pair not flagged");
    a_range_fault: assert property (take && one && cmd_op >= 3'h2 && cmd_op <= 3'h6 |=> storage_fault)
        else $error("range command on uncached storage not faulted");
    a_untrans_ok: assert property (take && !cmd_xlated |=> !attr_error && !storage_fault)
        else $error("untranslated command refused");
    a_size_legal: assert property (piece_valid |-> piece_size <= 3'h4 || piece_size == 3'h7)
        else $error("piece size not legal");
    a_ea_align: assert property (piece_valid |-> (piece_ea[6:0] & ~(7'h7F << piece_size)) == 7'h00)
        else $error("piece main address misaligned");
    a_ls_align: assert property (piece_valid && piece_op <= 3'h1
        |-> (piece_ls[6:0] & ~(7'h7F << piece_size)) == 7'h00)
        else $error("piece local address misaligned");
    a_range_line: assert property (piece_valid && piece_op >= 3'h2 && piece_op <= 3'h6
        |-> piece_size == 3'h7 && piece_ea[6:0] == 7'h00)
        else $error("range piece not a whole line");
    a_no_wtci: assert property (piece_valid |-> !(piece_attr[0] && piece_attr[1]))
        else $error("piece carries refused attribute pair");
    a_piece_hold: assert property (piece_valid && !piece_ready
        |=> piece_valid && $stable(piece_ea) && $stable(piece_size))
        else $error("piece changed before taken");
    a_first_piece: assert property (take && !wtci && cmd_op <= 3'h1 && cmd_len != 0
        |-> ##[1:2] piece_valid)
        else $error("first piece late");
endmodule
bind dsa_splitter dsa_checker #(.EA_W(EA_W), .LS_AW(LS_AW), .LEN_W(LEN_W)) dsa_checker_inst (
    .clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_len, .cmd_attr, .cmd_xlated,
    .cmd_done, .attr_error, .storage_fault, .piece_valid, .piece_ready, .piece_op,
    .piece_size, .piece_attr, .piece_ls, .piece_ea);

/* bench/dsa_far_model.sv */
/*
 * Model of the coherent interconnect: takes pieces and logs them in order.
 * Assumes stall and slow change only between clock edges.
 */
`timescale 1ns/1ns
module dsa_far_model (
    input  wire        clk,
    input  wire        stall,
    input  wire        slow,
    input  wire        piece_valid,
    output wire        piece_ready,
    input  wire [2:0]  piece_op,
    input  wire [2:0]  piece_size,
    input  wire [3:0]  piece_attr,
    input  wire [17:0] piece_ls,
    input  wire [63:0] piece_ea
);
    logic       tick = 1'b0;
    logic [2:0] rop[$];
    logic [2:0] rsz[$];
    logic [3:0] rat[$];
    logic [63:0] rea[$];
    logic [17:0] rls[$];
    // A slow interconnect accepts only every second cycle, to exercise the hold.
    assign piece_ready = !stall && (!slow || tick);
    // Each piece is performed whole and in arrival order.
    always @(posedge clk) begin
        tick <= !tick;
        if (piece_valid && piece_ready) begin
            rop.push_back(piece_op);
            rsz.push_back(piece_size);
            rat.push_back(piece_attr);
            rea.push_back(piece_ea);
            rls.push_back(piece_ls);
        end
    end
endmodule

/* bench/tb.sv */
/*
 * Self-checking bench for the transfer splitter with a far-side model.
 * Assumes a 250 MHz clock and the splitter's default parameters.
 */
`timescale 1ns/1ns
`include "dsa_regs.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_xlated = 1'b0;
    logic stall = 1'b0, slow = 1'b0, piece_valid, piece_ready, cmd_ready, busy;
    logic cmd_done, attr_error, storage_fault;
    logic [2:0] cmd_op = 3'h0, piece_op, piece_size;
    logic [3:0] cmd_attr = 4'h0, piece_attr;
    logic [63:0] cmd_ea = 64'h0, piece_ea;
    logic [17:0] cmd_ls = 18'h0, piece_ls;
    logic [14:0] cmd_len = 15'h0;
    int fails = 0, tests_run = 0, ndone = 0, nerr = 0, nflt = 0;
    always #2 clk = ~clk;
    dsa_splitter dsa_splitter_inst (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_ea,
        .cmd_ls, .cmd_len, .cmd_attr, .cmd_xlated, .cmd_done, .attr_error, .storage_fault,
        .piece_valid, .piece_ready, .piece_op, .piece_size, .piece_attr, .piece_ls,
        .piece_ea, .busy);
    dsa_far_model dsa_far_model_inst (.clk, .stall, .slow, .piece_valid, .piece_ready,
        .piece_op, .piece_size, .piece_attr, .piece_ls, .piece_ea);
    always @(posedge clk) begin
        ndone <= ndone + (cmd_done === 1'b1);
        nerr <= nerr + (attr_error === 1'b1);
        nflt <= nflt + (storage_fault === 1'b1);
    end
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main addresses never alias this controller's own local storage.
    task automatic issue(input [2:0] op, input [63:0] ea, input [17:0] ls,
                         input [14:0] len, input [3:0] at, input xl);
        int k;
        int n;
        k = ndone + nerr + nflt;
        n = 0;
        dsa_far_model_inst.rsz.delete();
        dsa_far_model_inst.rea.delete();
        dsa_far_model_inst.rop.delete();
        dsa_far_model_inst.rat.delete();
        dsa_far_model_inst.rls.delete();
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_ea <= ea;
        cmd_ls <= ls;
        cmd_len <= len;
        cmd_attr <= at;
        cmd_xlated <= xl;
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (n < 300 && !(ndone + nerr + nflt > k && busy === 1'b0)) begin
            @(negedge clk);
            n++;
        end
        if (n == 300) fails++;
    endtask
    task automatic t_pieces;
        issue(`DSA_OP_GET, 64'h10, 18'h10, 15'h20, 4'h4, 1'b1);
        `CHK("qw count", 2, dsa_far_model_inst.rsz.size())
        `CHK("qw ea1", 64'h20, dsa_far_model_inst.rea[1])
        slow <= 1'b1;
        issue(`DSA_OP_PUT, 64'h3, 18'h3, 15'h5, 4'h4, 1'b1);
        `CHK("odd sizes", 6'o02, {dsa_far_model_inst.rsz[0], dsa_far_model_inst.rsz[1]})
        `CHK("odd ea1", 64'h4, dsa_far_model_inst.rea[1])
        issue(`DSA_OP_GET, 64'h10, 18'h18, 15'h10, 4'h4, 1'b1);
        `CHK("mixed size", 6'o33, {dsa_far_model_inst.rsz[0], dsa_far_model_inst.rsz[1]})
        `CHK("mixed ls1", 18'h20, dsa_far_model_inst.rls[1])
        slow <= 1'b0;
        issue(`DSA_OP_GET, 64'h80, 18'h0, 15'h80, 4'h4, 1'b1);
        `CHK("line", 3'h7, dsa_far_model_inst.rsz[0])
        issue(`DSA_OP_GET, 64'h0, 18'h0, 15'h0, 4'h4, 1'b1);
        `CHK("zero len", 0, dsa_far_model_inst.rsz.size())
        $display("t_pieces done");
    endtask
    task automatic t_attr;
        int e;
        e = nerr;
        issue(`DSA_OP_PUT, 64'h40, 18'h40, 15'h10, 4'h3, 1'b1);
        `CHK("wt ci", e + 1, nerr)
        `CHK("wt ci none", 0, dsa_far_model_inst.rsz.size())
        issue(`DSA_OP_GET, 64'h40, 18'h40, 15'h10, 4'hF, 1'b0);
        `CHK("untranslated", `DSA_ATTR_DFLT, dsa_far_model_inst.rat[0])
        $display("t_attr done");
    endtask
    task automatic t_range;
        int f;
        for (int op = 2; op <= 6; op++) begin
            issue(op[2:0], 64'h105, 18'h0, 15'h10, 4'h4, 1'b1);
            `CHK("range op", op[2:0], dsa_far_model_inst.rop[0])
            `CHK("range ea", 64'h100, dsa_far_model_inst.rea[0])
            f = nflt;
            issue(op[2:0], 64'h105, 18'h0, 15'h10, 4'h1 << op[0], 1'b1);
            `CHK("range fault", f + 1, nflt)
        end
        $display("t_range done");
    endtask
    task automatic t_stall;
        stall <= 1'b1;
        fork
            issue(`DSA_OP_GET, 64'h0, 18'h0, 15'h300, 4'h4, 1'b1);
            begin
                repeat (30) @(negedge clk);
                `CHK("full stalls", 1'b0, cmd_ready)
                `CHK("busy stalled", 1'b1, busy)
                `CHK("head shown", 1'b1, piece_valid)
                stall <= 1'b0;
            end
        join
        `CHK("lines", 6, dsa_far_model_inst.rea.size())
        `CHK("last line", 64'h280, dsa_far_model_inst.rea[5])
        $display("t_stall done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_pieces();
        t_attr();
        t_range();
        t_stall();
        tally_and_finish();
    end
    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule
